//--- logic/iox_alu.v
// Increment and OR datapath with zero detect
`timescale 1ns/100ps
`default_nettype none

module iox_alu (
  input  wire [7:0] file_i,     // Addressed file register value
  input  wire [7:0] w_i,        // Working register value
  input  wire [7:0] lit_i,      // Literal field
  input  wire       sel_or_i,   // High selects OR, low increment
  output wire [7:0] result_o,   // Operation result
  output wire       zero_o      // Result is zero
);

  // Increment wraps modulo 256: 8-bit sum drops the carry
  wire [7:0] inc_val;
  assign inc_val  = file_i + 8'h01;
  assign result_o = sel_or_i ? (w_i | lit_i) : inc_val;
  assign zero_o   = (result_o == 8'h00);

endmodule

`default_nettype wire

//--- logic/iox_exec.v
// Execute unit for increment, increment-skip and OR-literal instructions
//
// What this block does
// - Both increments add one to the addressed file register; only the plain form updates zero.
// - Increment results go to W when d is 0, else to the file register.
// - A zero increment-skip result turns the next word into a no-op.
// - OR-literal ORs the literal into the working register, sets zero.
`timescale 1ns/100ps
`default_nettype none
`include "iox_regs.vh"

module iox_exec (
  input  wire        clk_sys_i,    // Instruction clock
  input  wire        nrst_i,       // Async reset, active low
  input  wire        ce_i,         // Clock enable, freezes state when low
  input  wire        valid_i,      // Instruction word is valid this cycle
  input  wire [13:0] insn_i,       // Instruction word
  input  wire [7:0]  file_data_i,  // Contents of addressed file register
  output wire [6:0]  file_addr_o,  // File register address
  output reg  [7:0]  file_wdata_o, // File write data
  output reg         file_we_o,    // File write strobe, one cycle
  output wire [7:0]  w_o,          // Working register
  output wire        zero_o,       // Zero flag
  output reg         flush_o,      // Discard next fetched instruction
  output wire        hit_o         // Word is one of the handled opcodes
);

  // Sequencer states: normal issue, or the slot whose word is dropped
  localparam ST_RUN   = 1'b0;
  localparam ST_FLUSH = 1'b1;

  // Architectural state and next values
  reg  [7:0] w_reg;
  reg  [7:0] w_next;
  reg        z_reg;
  reg        z_next;
  reg        st_reg;
  reg        st_next;

  // Output register next values
  reg        we_next;
  reg  [7:0] wd_next;
  reg        fl_next;

  // Instruction fields
  wire [5:0] opcode;
  wire       dest;
  wire [7:0] lit;

  // Decode and routing qualifiers
  wire       in_slot;
  wire       take;
  wire       is_inc;
  wire       is_skip;
  wire       is_or;
  wire       any_inc;
  wire       to_file;
  wire       to_w;

  // Datapath results
  wire [7:0] result;
  wire       res_zero;

  // Opcode compare, used for each instruction
  function op_is;
    input [5:0] op;
    input [5:0] pat;
    begin
      op_is = (op == pat);
    end
  endfunction

  // Either file increment form; both share the routing by d
  function inc_form;
    input [5:0] op;
    begin
      inc_form = op_is(op, `IOX_OP_INC) | op_is(op, `IOX_OP_INCSKIP);
    end
  endfunction

  // Field extraction; the address goes straight to the register file
  assign opcode      = insn_i[`IOX_OP_HI:`IOX_OP_LO];
  assign dest        = insn_i[`IOX_DEST_BIT];
  assign lit         = insn_i[`IOX_LIT_HI:`IOX_LIT_LO];
  assign file_addr_o = insn_i[`IOX_ADDR_HI:`IOX_ADDR_LO];

  // Slot after a zero skip result: its word is never decoded
  assign in_slot = (st_reg == ST_FLUSH);

  // Word executes on this edge unless it sits in the slot
  assign take    = valid_i && !in_slot;

  // Opcode decode; other words leave all state alone
  assign is_inc  = take && op_is(opcode, `IOX_OP_INC);
  assign is_skip = take && op_is(opcode, `IOX_OP_INCSKIP);
  assign is_or   = take && op_is(opcode, `IOX_OP_ORLIT);
  assign any_inc = take && inc_form(opcode);

  // Handled-word indicator for the surrounding core
  assign hit_o   = any_inc | is_or;

  // Increment results routed by the destination bit
  assign to_file = any_inc && dest;
  assign to_w    = any_inc && !dest;

  // Registered state drives the outputs directly
  assign w_o    = w_reg;
  assign zero_o = z_reg;

  // Shared datapath: increment for both file forms, OR for the literal.
  // Its select is the only decode it sees.
  iox_alu u_alu (
    .file_i   (file_data_i),
    .w_i      (w_reg),
    .lit_i    (lit),
    .sel_or_i (is_or),
    .result_o (result),
    .zero_o   (res_zero)
  );

  // Working register: increment with d clear, or OR-literal result
  always @* begin
    w_next = w_reg;
    if (to_w) begin
      w_next = result;
    end
    if (is_or) begin
      w_next = result;
    end
  end

  // Zero flag: plain increment and OR-literal only.
  // Skip form keeps it, even on the cycle that skips.
  always @* begin
    z_next = z_reg;
    if (is_inc) begin
      z_next = res_zero;
    end
    if (is_or) begin
      z_next = res_zero;
    end
  end

  // File write port: one-cycle strobe, data held between writes
  always @* begin
    we_next = 1'b0;
    wd_next = file_wdata_o;
    if (to_file) begin
      we_next = 1'b1;
      wd_next = result;
    end
  end

  // Skip sequencing: a zero result turns the next slot into a no-op
  always @* begin
    st_next = ST_RUN;
    fl_next = 1'b0;
    case (st_reg)
      ST_RUN: begin
        if (is_skip && res_zero) begin
          st_next = ST_FLUSH;
          fl_next = 1'b1;
        end
      end
      ST_FLUSH: begin
        // Discarded word is already kept out of the decode
        st_next = ST_RUN;
      end
      default: begin
        st_next = ST_RUN;
      end
    endcase
  end

  // Working register and zero flag; low enable freezes both
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_reg <= `IOX_W_RST;
      z_reg <= `IOX_Z_RST;
    end else if (ce_i) begin
      w_reg <= w_next;
      z_reg <= z_next;
    end
  end

  // Write strobe, one pulse per increment bound for the file
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      file_we_o <= 1'b0;
    end else if (ce_i) begin
      file_we_o <= we_next;
    end
  end

  // Write data held between writes, so idle cycles keep the bus quiet
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      file_wdata_o <= 8'h00;
    end else if (ce_i) begin
      file_wdata_o <= wd_next;
    end
  end

  // Sequencer state and the flush pulse marking the no-op slot.
  // Low enable stretches the slot too, so the discarded word
  // must stay presented until the next enabled edge.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg  <= ST_RUN;
      flush_o <= 1'b0;
    end else if (ce_i) begin
      st_reg  <= st_next;
      flush_o <= fl_next;
    end
  end

endmodule

`default_nettype wire

//--- logic/iox_regs.vh
// Opcode patterns, field positions and widths for the execute unit
`ifndef IOX_REGS_VH
`define IOX_REGS_VH

`define IOX_INSN_W      14
`define IOX_DATA_W      8
`define IOX_ADDR_W      7
// Opcode field, bits 13..8
`define IOX_OP_HI       13
`define IOX_OP_LO       8
`define IOX_OP_INC      6'h0a
`define IOX_OP_INCSKIP  6'h0f
`define IOX_OP_ORLIT    6'h38
// Destination bit and address field
`define IOX_DEST_BIT    7
`define IOX_ADDR_HI     6
`define IOX_ADDR_LO     0
// Literal field
`define IOX_LIT_HI      7
`define IOX_LIT_LO      0
// Reset values
`define IOX_W_RST       8'h00
`define IOX_Z_RST       1'h0
// Instruction cycle time and cycles per instruction cycle
`define IOX_TCY_NS      10
`define IOX_CLK_NS      10
`define IOX_TCY_CYC     ((`IOX_TCY_NS + `IOX_CLK_NS - 1) / `IOX_CLK_NS)

`endif

//--- verification/iox_exec_monitor.sv
// Checker for the increment and OR-literal execute unit
`timescale 1ns/100ps
`default_nettype none
module iox_exec_monitor (
  input wire logic        clk_sys_i,    // Clock
  input wire logic        nrst_i,       // Reset, low
  input wire logic        ce_i,         // Enable
  input wire logic        valid_i,      // Word valid
  input wire logic [13:0] insn_i,       // Word
  input wire logic [7:0]  file_data_i,  // File read
  input wire logic [7:0]  file_wdata_o, // File data
  input wire logic        file_we_o,    // File write
  input wire logic [7:0]  w_o,          // Work reg
  input wire logic        zero_o,       // Zero
  input wire logic        flush_o       // Flush
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Words in the flush slot are never taken
  wire [5:0] op = insn_i[13:8];
  wire [7:0] lit = insn_i[7:0];
  wire go = ce_i && valid_i && !flush_o;
  wire inc = go && (op == 6'h0a || op == 6'h0f);
  // Pulse, then the slot word is dropped
  sequence flush_slot;
    flush_o ##1 (!flush_o && !file_we_o);
  endsequence
  chk_inc_write: assert property (
    inc && insn_i[7] |=> file_we_o && file_wdata_o == $past(file_data_i)
      + 8'h01) else $error("bad file write");
  chk_inc_to_w: assert property (
    inc && !insn_i[7] |=> !file_we_o && w_o == $past(file_data_i) + 8'h01)
    else $error("bad working write");
  chk_inc_zero: assert property (
    go && op == 6'h0a |=> zero_o == ($past(file_data_i) == 8'hff))
    else $error("bad zero on increment");
  chk_skip_keeps_z: assert property (
    go && op == 6'h0f |=> $stable(zero_o)) else $error("zero moved");
  chk_skip_flush: assert property (
    go && op == 6'h0f && file_data_i == 8'hff |=> flush_slot)
    else $error("missing flush");
  chk_no_flush: assert property (
    go && op == 6'h0f && file_data_i != 8'hff |=> !flush_o)
    else $error("spurious flush");
  chk_or_lit: assert property (
    go && op == 6'h38 |=> w_o == ($past(w_o) | $past(lit))
      && zero_o == (w_o == 8'h00)) else $error("bad literal or");
endmodule
bind iox_exec iox_exec_monitor mon (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .ce_i(ce_i), .valid_i(valid_i), .insn_i(insn_i),
  .file_data_i(file_data_i), .file_wdata_o(file_wdata_o),
  .file_we_o(file_we_o), .w_o(w_o), .zero_o(zero_o), .flush_o(flush_o));
`default_nettype wire

//--- verification/iox_exec_tb.sv
// Random and corner stimulus for the execute unit
`timescale 1ns/100ps
`default_nettype none
module iox_exec_tb;
  logic clk_sys_i = 0, nrst_i = 0, ce_i = 0, valid_i = 0;
  logic [13:0] insn_i = 14'h0000;
  logic [7:0] file_data_i = 8'h00, ew = 8'h00, r;
  logic [15:0] lf = 16'h0004;
  logic [5:0] op, ops [4] = '{6'h0a, 6'h0f, 6'h38, 6'h05};
  logic ez = 0, tk, ewe, ef, sk = 0, en;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  wire [7:0] fwd, w;
  wire [6:0] fa;
  wire fwe, z, fl, hit;
  iox_exec uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .valid_i(valid_i), .insn_i(insn_i), .file_data_i(file_data_i),
    .file_addr_o(fa), .file_wdata_o(fwd), .file_we_o(fwe), .w_o(w),
    .zero_o(z), .flush_o(fl), .hit_o(hit));
  always #5 clk_sys_i = ~clk_sys_i;
  // Ceiling far above the 420 cycles needed
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      wrap_up;
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected increment, wrapping at 8 bits
  function automatic logic [7:0] inc8(input logic [7:0] v);
    return v + 8'h01;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Back-to-back skips on 0xff first, then random words
  initial begin
    repeat (20) @(negedge clk_sys_i);
    chk(w, 8'h00);
    chk(z, 8'h00);
    nrst_i = 1;
    $display("reset test done");
    for (int i = 0; i < 400; i++) begin
      lf = lfsr(lf);
      op = i < 4 ? 6'h0f : ops[lf[1:0]];
      insn_i = {op, lf[15:8]};
      file_data_i = (i < 4 || lf[3:2] == 0) ? 8'hff : lf[11:4];
      // Corner words and the slot after a flush are always enabled
      ce_i = sk | (i < 4) | lf[4] | lf[5];
      valid_i = sk | (i < 4) | lf[6] | lf[7];
      r = inc8(file_data_i);
      tk = ce_i && valid_i && !sk && op != 6'h05;
      ewe = tk && op != 6'h38 && insn_i[7];
      ef = tk && op == 6'h0f && r == 0;
      if (tk && op == 6'h38) ew = ew | insn_i[7:0];
      if (tk && op != 6'h38 && !insn_i[7]) ew = r;
      if (tk && op != 6'h0f) ez = (op == 6'h38) ? ew == 0 : r == 0;
      en = ce_i;
      #1 chk(hit, valid_i && !sk && op != 6'h05);
      chk({1'b0, fa}, {1'b0, insn_i[6:0]});
      @(negedge clk_sys_i);
      chk(w, ew);
      chk(z, ez);
      if (en) begin
        chk(fwe, ewe);
        chk(fl, ef);
        if (ewe) chk(fwd, r);
      end
      sk = ef;
    end
    $display("random test done");
    wrap_up;
  end
endmodule
`default_nettype wire
